// *** hw/lfpr_fuse_readback.sv ***
// Fuse contents readback command handler of a LIN slave, frame level.
`timescale 1ns/10ps
module lfpr_fuse_readback (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_reset_n,
   input  wire lfpr_pkg::lfpr_fuse_t i_fuse,
   input  wire logic                 i_req_valid,
   input  wire lfpr_pkg::lfpr_frame_t i_req_frame,
   input  wire logic                 i_rsp_hdr_valid,
   input  wire logic [7:0]           i_rsp_hdr_pid,
   input  wire logic                 i_cmd_valid,
   input  wire logic                 i_cmd_is_color_short,
   input  wire logic                 i_cmd_is_intensity,
   output logic                      o_cmd_accept,
   output logic                      o_cmds_disabled,
   output logic                      o_req_taken,
   output logic                      o_rsp_valid,
   output lfpr_pkg::lfpr_frame_t     o_rsp_frame
);

   typedef enum logic [1:0] {
      LFPR_IDLE,
      LFPR_HALF1_PENDING,
      LFPR_HALF2_PENDING
   } lfpr_state_t;

   // Classic checksum: carry-wrapping byte sum over data only, then inverted.
   function automatic lfpr_pkg::lfpr_byte_t lfpr_checksum(input lfpr_pkg::lfpr_data_t d);
      logic [8:0] acc;
      acc = 9'h000;
      for (int k = 1; k <= lfpr_pkg::LFPR_NUM_DATA; k++) begin
         acc = {1'b0, acc[7:0]} + {1'b0, d[k]} + {8'h00, acc[8]};
      end
      acc = {1'b0, acc[7:0]} + {8'h00, acc[8]};
      return ~acc[7:0];
   endfunction

   lfpr_state_t           state_reg;
   lfpr_state_t           state_next;
   logic                  rsp_valid_reg;
   lfpr_pkg::lfpr_frame_t rsp_frame_reg;
   lfpr_pkg::lfpr_frame_t rsp_frame_next;

   wire logic [7:0] addr_byte = {lfpr_pkg::LFPR_ADDR_TOP_BITS, i_fuse.node_address};
   wire lfpr_pkg::lfpr_coef_t coef = i_fuse.calib_matrix_coef;
   wire lfpr_pkg::lfpr_data_t rq = i_req_frame.data;

   // Fill bytes four to eight must all read 0xff.
   logic [lfpr_pkg::LFPR_NUM_DATA:lfpr_pkg::LFPR_FILL_FIRST_BYTE] fill_ok;
   genvar g;
   generate
      for (g = lfpr_pkg::LFPR_FILL_FIRST_BYTE; g <= lfpr_pkg::LFPR_NUM_DATA; g++) begin : g_fill
         assign fill_ok[g] = (rq[g] == lfpr_pkg::LFPR_FILL_BYTE);
      end
   endgenerate

   wire logic cmds_off   = i_fuse.commands_disable_fuse;
   wire logic req_frame  = i_req_valid && (i_req_frame.pid == lfpr_pkg::LFPR_PID_MASTER_REQ);
   wire logic csum_ok    = (i_req_frame.checksum == lfpr_checksum(rq));
   wire logic head_ok    = (rq[1] == lfpr_pkg::LFPR_APP_CMD) && (rq[3] == addr_byte)
                           && (&fill_ok);
   wire logic is_half1   = (rq[2] == {1'b1, lfpr_pkg::LFPR_CMD_READ_HALF1});
   wire logic is_half2   = (rq[2] == {1'b1, lfpr_pkg::LFPR_CMD_READ_HALF2});
   wire logic req_good   = req_frame && csum_ok && head_ok && !cmds_off;
   wire logic take_half1 = req_good && is_half1;
   wire logic take_half2 = req_good && is_half2;
   wire logic rsp_slot   = i_rsp_hdr_valid && (i_rsp_hdr_pid == lfpr_pkg::LFPR_PID_SLAVE_RSP);
   wire logic rsp_fire   = rsp_slot && (state_reg != LFPR_IDLE);

   // First half: address, configuration flags, first coefficient row.
   wire lfpr_pkg::lfpr_data_t half1_data;
   assign half1_data[1] = addr_byte;
   assign half1_data[2] = {6'h3f, i_fuse.low_rate, i_fuse.diag_suppress_all};
   assign half1_data[3] = 8'hff;
   assign half1_data[4] = {i_fuse.default_cfg, i_fuse.error_report_off,
                           i_fuse.thermal_warn_level, 5'h1f};
   assign half1_data[5] = {i_fuse.fuse_lock_first, i_fuse.commands_disable_fuse,
                           i_fuse.node_address};
   generate
      for (g = 0; g < lfpr_pkg::LFPR_FIRST_ROW_COEFS; g++) begin : g_row1
         assign half1_data[6 + g] = coef[g];
      end
   endgenerate

   // Second half: address, remaining six coefficients, second flag byte.
   wire lfpr_pkg::lfpr_data_t half2_data;
   assign half2_data[1] = addr_byte;
   generate
      for (g = 0; g < lfpr_pkg::LFPR_NUM_COEF - lfpr_pkg::LFPR_FIRST_ROW_COEFS; g++) begin : g_rows
         assign half2_data[2 + g] = coef[lfpr_pkg::LFPR_FIRST_ROW_COEFS + g];
      end
   endgenerate
   assign half2_data[8] = {i_fuse.fuse_lock_second, i_fuse.pwm_rate_select, 1'b1,
                           i_fuse.thermal_control, i_fuse.group_number};

   wire lfpr_pkg::lfpr_data_t sel_data =
      (state_reg == LFPR_HALF2_PENDING) ? half2_data : half1_data;

   always_comb begin
      rsp_frame_next = rsp_frame_reg;
      if (rsp_fire) begin
         rsp_frame_next.pid      = lfpr_pkg::LFPR_PID_SLAVE_RSP;
         rsp_frame_next.data     = sel_data;
         rsp_frame_next.checksum = lfpr_checksum(sel_data);
      end
   end

   // A new master request frame always replaces what was pending; a bad one cancels it.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         LFPR_IDLE: begin
            state_next = LFPR_IDLE;
         end
         LFPR_HALF1_PENDING,
         LFPR_HALF2_PENDING: begin
            if (rsp_slot) begin
               state_next = LFPR_IDLE;
            end
         end
         default: begin
            state_next = LFPR_IDLE;
         end
      endcase
      if (take_half1) begin
         state_next = LFPR_HALF1_PENDING;
      end else if (take_half2) begin
         state_next = LFPR_HALF2_PENDING;
      end else if (req_frame) begin
         state_next = LFPR_IDLE;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg     <= LFPR_IDLE;
         rsp_valid_reg <= 1'b0;
         rsp_frame_reg <= lfpr_pkg::LFPR_FRAME_RESET;
      end else begin
         state_reg     <= state_next;
         rsp_valid_reg <= rsp_fire;
         rsp_frame_reg <= rsp_frame_next;
      end
   end

   assign o_cmds_disabled = cmds_off;
   assign o_cmd_accept    = i_cmd_valid && (!cmds_off || i_cmd_is_color_short
                                            || i_cmd_is_intensity);
   assign o_req_taken     = take_half1 || take_half2;
   assign o_rsp_valid     = rsp_valid_reg;
   assign o_rsp_frame     = rsp_frame_reg;

endmodule // lfpr_fuse_readback

// *** hw/lfpr_pkg.sv ***
// Package for the fuse readback command handler: constants and carrier types.
package lfpr_pkg;

   localparam logic [7:0] LFPR_PID_MASTER_REQ   = 8'h3c;
   localparam logic [7:0] LFPR_PID_SLAVE_RSP    = 8'h7d;
   localparam logic [7:0] LFPR_APP_CMD          = 8'h80;
   localparam logic [6:0] LFPR_CMD_READ_HALF1   = 7'h04;
   localparam logic [6:0] LFPR_CMD_READ_HALF2   = 7'h05;
   localparam logic [7:0] LFPR_FILL_BYTE        = 8'hff;
   localparam logic [1:0] LFPR_ADDR_TOP_BITS    = 2'b11;
   localparam int         LFPR_NUM_DATA         = 8;
   localparam int         LFPR_NUM_COEF         = 9;
   localparam int         LFPR_FIRST_ROW_COEFS  = 3;
   localparam int         LFPR_FILL_FIRST_BYTE  = 4;

   typedef logic [7:0] lfpr_byte_t;
   typedef lfpr_byte_t [1:LFPR_NUM_DATA] lfpr_data_t;
   typedef lfpr_byte_t [0:LFPR_NUM_COEF-1] lfpr_coef_t;

   // One LIN frame as seen by the frame layer: protected identifier, data, checksum.
   typedef struct packed {
      lfpr_byte_t pid;
      lfpr_data_t data;
      lfpr_byte_t checksum;
   } lfpr_frame_t;

   // Contents of the one-time-programmable configuration memory.
   typedef struct packed {
      logic       low_rate;
      logic       diag_suppress_all;
      logic       default_cfg;
      logic       error_report_off;
      logic       thermal_warn_level;
      logic       fuse_lock_first;
      logic       commands_disable_fuse;
      logic [5:0] node_address;
      lfpr_coef_t calib_matrix_coef;
      logic       fuse_lock_second;
      logic       pwm_rate_select;
      logic       thermal_control;
      logic [3:0] group_number;
   } lfpr_fuse_t;

   localparam lfpr_frame_t LFPR_FRAME_RESET = '0;

endpackage

// *** verification/lfpr_fuse_readback_sva.sv ***
// Assertions on the ports of the fuse readback handler.
`timescale 1ns/10ps
module lfpr_fuse_readback_sva (
   input logic                  i_ref_clk,
   input logic                  i_reset_n,
   input lfpr_pkg::lfpr_fuse_t  i_fuse,
   input logic                  i_req_valid,
   input lfpr_pkg::lfpr_frame_t i_req_frame,
   input logic                  i_rsp_hdr_valid,
   input logic [7:0]            i_rsp_hdr_pid,
   input logic                  i_cmd_valid,
   input logic                  i_cmd_is_color_short,
   input logic                  i_cmd_is_intensity,
   input logic                  o_cmd_accept,
   input logic                  o_req_taken,
   input logic                  o_rsp_valid,
   input lfpr_pkg::lfpr_frame_t o_rsp_frame
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   a_rsp_one_cycle: assert property (o_rsp_valid |=> !o_rsp_valid)
      else $error("Response valid too long.");
   a_rsp_cause: assert property (o_rsp_valid |-> $past(i_rsp_hdr_valid && i_rsp_hdr_pid == 8'h7d))
      else $error("Response without header.");
   a_rsp_pid: assert property (o_rsp_valid |-> o_rsp_frame.pid == 8'h7d)
      else $error("Response pid wrong.");
   a_rsp_addr: assert property (o_rsp_valid |-> o_rsp_frame.data[1] == {2'b11, i_fuse.node_address})
      else $error("Response address wrong.");
   a_rsp_coefs: assert property (o_rsp_valid |-> o_rsp_frame.data[6:8] == i_fuse.calib_matrix_coef[0:2]
      || o_rsp_frame.data[2:7] == i_fuse.calib_matrix_coef[3:8]) else $error("Coefs wrong.");
   a_cmd_gate: assert property (o_cmd_accept == (i_cmd_valid && (!i_fuse.commands_disable_fuse
      || i_cmd_is_color_short || i_cmd_is_intensity))) else $error("Command gate wrong.");
   a_taken_gate: assert property (o_req_taken |-> i_req_valid && i_req_frame.pid == 8'h3c
      && !i_fuse.commands_disable_fuse) else $error("Request taken wrongly.");
   a_frame_holds: assert property (!o_rsp_valid |-> $stable(o_rsp_frame))
      else $error("Response frame moved.");
endmodule // lfpr_fuse_readback_sva
bind lfpr_fuse_readback lfpr_fuse_readback_sva chk (.*);

// *** verification/lfpr_lin_master.sv ***
// LIN master model: readback requests and response headers.
`timescale 1ns/10ps
module lfpr_lin_master (
   input  wire logic             i_ref_clk,
   output lfpr_pkg::lfpr_frame_t o_req_frame = '0,
   output logic                  o_req_valid = 1'b0,
   output logic                  o_hdr_valid = 1'b0,
   output logic [7:0]            o_hdr_pid = 8'h00
);
   function automatic logic [7:0] csum(input lfpr_pkg::lfpr_data_t d);
      int s;
      s = 0;
      for (int i = 1; i <= 8; i++) begin
         s = s + d[i] - ((s + d[i] > 255) ? 255 : 0);
      end
      return ~s[7:0];
   endfunction
   task automatic send(input logic [6:0] c, input logic [5:0] a, input logic e);
      lfpr_pkg::lfpr_data_t d;
      d = {8'h80, 1'b1, c, 2'b11, a, 40'hffffffffff};
      @(negedge i_ref_clk);
      o_req_frame = {8'h3c, d, csum(d) ^ 8'(e)};
      o_req_valid = 1'b1;
      @(negedge i_ref_clk);
      o_req_valid = 1'b0;
      o_req_frame = ~o_req_frame;
   endtask
   task automatic hdr(input logic [7:0] p);
      @(negedge i_ref_clk);
      o_hdr_pid = p;
      o_hdr_valid = 1'b1;
      @(negedge i_ref_clk);
      o_hdr_valid = 1'b0;
      o_hdr_pid = ~p;
   endtask
endmodule // lfpr_lin_master

// *** verification/test_lfpr_fuse_readback.sv ***
// Self-checking bench for the fuse readback handler.
`timescale 1ns/10ps
module test_lfpr_fuse_readback;
   typedef struct packed {logic [6:0] c; logic [5:0] a; logic e; logic [1:0] h;} lfpr_row_t;
   localparam lfpr_row_t ROWS [4] = '{'{7'h04, 6'h15, 1'b0, 2'h1}, '{7'h05, 6'h15, 1'b0, 2'h2},
      '{7'h04, 6'h15, 1'b1, 2'h0}, '{7'h05, 6'h2a, 1'b0, 2'h0}};
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  cv = 1'b0;
   logic                  cs = 1'b0;
   logic                  ci = 1'b0;
   logic                  acc, dis, tk, rv, qv, hv;
   logic [7:0]            hp;
   lfpr_pkg::lfpr_frame_t rf, qf;
   lfpr_pkg::lfpr_fuse_t  fz = {7'h54, 6'h15, 72'h1122334455667788a9, 7'h5a};
   int                    bad_count = 0;
   int                    comparisons = 0;
   int                    taken = 0;
   int                    taken_seen = 0;
   always @(posedge clk) begin
      if (tk === 1'b1) begin
         taken++;
      end
   end
   initial begin
      forever #5 clk = ~clk;
   end
   lfpr_lin_master m (.i_ref_clk(clk), .o_req_frame(qf), .o_req_valid(qv), .o_hdr_valid(hv),
      .o_hdr_pid(hp));
   lfpr_fuse_readback dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_fuse(fz), .i_req_valid(qv),
      .i_req_frame(qf), .i_rsp_hdr_valid(hv), .i_rsp_hdr_pid(hp), .i_cmd_valid(cv),
      .i_cmd_is_color_short(cs), .i_cmd_is_intensity(ci), .o_cmd_accept(acc),
      .o_cmds_disabled(dis), .o_req_taken(tk), .o_rsp_valid(rv), .o_rsp_frame(rf));
   task automatic check(input string n, input logic [79:0] e, input logic [79:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic lfpr_pkg::lfpr_frame_t rsp(input logic [1:0] h);
      lfpr_pkg::lfpr_data_t d;
      d = (h == 2'h1) ? {2'b11, fz.node_address, 6'h3f, fz.low_rate, fz.diag_suppress_all, 8'hff,
         fz.default_cfg, fz.error_report_off, fz.thermal_warn_level, 5'h1f, fz.fuse_lock_first,
         fz.commands_disable_fuse, fz.node_address, fz.calib_matrix_coef[0:2]}
         : {2'b11, fz.node_address, fz.calib_matrix_coef[3:8], fz.fuse_lock_second,
         fz.pwm_rate_select, 1'b1, fz.thermal_control, fz.group_number};
      return {8'h7d, d, m.csum(d)};
   endfunction
   task automatic hdr_check(input logic [1:0] h);
      m.hdr(8'h7d);
      for (int k = 0; k < 3 && rv !== 1'b1; k++) @(negedge clk);
      check("rsp valid", 80'(h != 2'h0), 80'(rv));
      if (h != 2'h0) check("rsp frame", rsp(h), rf);
      @(negedge clk);
   endtask
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d.", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      check("reset rsp", 80'h0, rf | 80'(rv));
      foreach (ROWS[i]) begin
         taken_seen = taken;
         m.send(ROWS[i].c, ROWS[i].a, ROWS[i].e);
         check("req taken", 80'(ROWS[i].h != 2'h0), 80'(taken - taken_seen));
         hdr_check(ROWS[i].h);
      end
      m.send(7'h05, 6'h15, 1'b0);
      m.send(7'h04, 6'h15, 1'b0);
      hdr_check(2'h1);
      hdr_check(2'h0);
      $display("Readback tests done.");
      fz.commands_disable_fuse = 1'b1;
      taken_seen = taken;
      m.send(7'h04, 6'h15, 1'b0);
      check("req taken", 80'h0, 80'(taken - taken_seen));
      hdr_check(2'h0);
      for (int j = 0; j < 16; j++) begin
         {fz.commands_disable_fuse, cv, cs, ci} = 4'(j);
         @(negedge clk);
         check("accept", 80'(cv & (~fz.commands_disable_fuse | cs | ci)), 80'(acc));
         check("disabled", 80'(fz.commands_disable_fuse), 80'(dis));
      end
      $display("Command gate test done.");
      stop_test();
   end
endmodule // test_lfpr_fuse_readback
